/* common/esr_pkg.sv */
// Purpose: Shared constants and types for the eight-stage shift register block
// Assumes: One program clock, synchronous active-high reset
// Notes: Stage 1 is bit 0, stage 8 is bit 7
package esr_pkg;
	localparam int STAGES = 8;
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_LAST = 3'h7;
	localparam int FIFO_DEPTH = 32;
	localparam logic [7:0] STAGE_RESET = 8'h00;
	localparam logic DIR_UP = 1'h0;
	localparam logic DIR_DOWN = 1'h1;

	// One shift request: serial bit and direction, sampled together
	typedef struct packed {
		logic data;
		logic dir;
	} esr_req_t;

	typedef enum logic [1:0] {
		ESR_COLD = 2'b00,
		ESR_RUN = 2'b01
	} esr_state_t;
endpackage

/* src/esr_fifo.sv */
// Purpose: Holds no code; the request FIFO sits beside the shift register block
// Assumes: Nothing
// Notes: Keeping the FIFO next to its only user keeps all logic together

/* src/esr_shift_reg.sv */
// Function
// - Rising trigger edge samples serial input and shifts it in
// - Falling trigger edge changes nothing
// - Direction low shifts upward, first stage toward last stage
// - Direction high shifts downward, last stage toward first stage
// - Upward: input enters first stage, each stage takes one below
// - Downward: input enters last stage, each stage takes one above
// - Output always equals the stage chosen by the select parameter
// - Retentive option keeps all eight stages across power loss
// - Non-retentive: contents lost at restart, shifting starts afresh
//
// Purpose: Eight-stage bidirectional shift register function block
// Assumes: Inputs come from logic on core_clk; power_up marks a power restart
// Notes: Requests queue in a FIFO; stages update when the FIFO drains
`timescale 1ns/1ns
`default_nettype none
module esr_shift_reg #(
	parameter logic [2:0] OUT_SEL = esr_pkg::SEL_LAST,
	parameter bit RETAIN = 1'b0,
	parameter int DEPTH = esr_pkg::FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic power_up,
	input wire logic trigger,
	input wire logic serial_in,
	input wire logic dir,
	input wire logic drain_ready,
	output logic stage_out,
	output logic [esr_pkg::STAGES-1:0] stages,
	output logic req_ready
);
	import esr_pkg::*;

	logic trigger_prev;
	logic rise;
	esr_req_t req;
	esr_req_t head;
	logic head_valid;
	logic take;
	logic fifo_ready;
	logic [STAGES-1:0] next_stages;

	// Edge against last program cycle's level
	assign rise = trigger && !trigger_prev;
	assign req = '{data: serial_in, dir: dir};
	assign take = head_valid && drain_ready;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trigger_prev <= 1'b0;
		end else begin
			trigger_prev <= trigger;
		end
	end

	// A full FIFO drops the edge; req_ready warns the program to pace triggers
	esr_fifo #(.WIDTH($bits(esr_req_t)), .DEPTH(DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(rise),
		.in_ready(fifo_ready),
		.in_data(req),
		.out_valid(head_valid),
		.out_ready(drain_ready),
		.out_data(head)
	);

	always_comb begin
		if (head.dir == DIR_UP) begin
			next_stages = {stages[STAGES-2:0], head.data};
		end else begin
			next_stages = {head.data, stages[STAGES-1:1]};
		end
	end

	// Retention models power loss: power_up only clears when not retentive
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stages <= STAGE_RESET;
		end else if (power_up && !RETAIN) begin
			stages <= STAGE_RESET;
		end else if (take) begin
			stages <= next_stages;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage_out <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			stage_out <= next_out();
			req_ready <= fifo_ready;
		end
	end

	function automatic logic next_out();
		if (rst) begin
			return 1'b0;
		end
		if (power_up && !RETAIN) begin
			return 1'b0;
		end
		if (take) begin
			return next_stages[OUT_SEL];
		end
		return stages[OUT_SEL];
	endfunction

	// Shift checks skip power_up cycles, where a non-retentive clear wins
	chk_fall_no_shift: assert property (@(posedge core_clk) disable iff (rst)
		(!head_valid && !power_up) |=> $stable(stages))
		else $error("stages changed without a queued edge");
	chk_up_entry: assert property (@(posedge core_clk) disable iff (rst)
		(take && !power_up && head.dir == DIR_UP) |=> stages[0] == $past(head.data))
		else $error("upward shift did not load first stage");
	chk_up_move: assert property (@(posedge core_clk) disable iff (rst)
		(take && !power_up && head.dir == DIR_UP)
		|=> stages[STAGES-1:1] == $past(stages[STAGES-2:0]))
		else $error("upward shift moved stages wrongly");
	chk_down_entry: assert property (@(posedge core_clk) disable iff (rst)
		(take && !power_up && head.dir == DIR_DOWN)
		|=> stages[STAGES-1] == $past(head.data))
		else $error("downward shift did not load last stage");
	chk_down_move: assert property (@(posedge core_clk) disable iff (rst)
		(take && !power_up && head.dir == DIR_DOWN)
		|=> stages[STAGES-2:0] == $past(stages[STAGES-1:1]))
		else $error("downward shift moved stages wrongly");
	chk_out_select: assert property (@(posedge core_clk) disable iff (rst)
		stage_out == stages[OUT_SEL])
		else $error("output does not follow selected stage");
	chk_edge_queue: assert property (@(posedge core_clk) disable iff (rst)
		(rise && fifo_ready && !head_valid) |=> head_valid ##0 head.data == $past(serial_in))
		else $error("rising edge not queued with sampled input");
	chk_dir_queue: assert property (@(posedge core_clk) disable iff (rst)
		(rise && fifo_ready && !head_valid) |=> head.dir == $past(dir))
		else $error("rising edge not queued with sampled direction");
	chk_power_clear: assert property (@(posedge core_clk) disable iff (rst)
		(power_up && !RETAIN) |=> stages == STAGE_RESET)
		else $error("non-retentive restart kept stage contents");
	chk_power_out: assert property (@(posedge core_clk) disable iff (rst)
		(power_up && !RETAIN) |=> !stage_out)
		else $error("non-retentive restart kept the output high");
	chk_retain_keep: assert property (@(posedge core_clk) disable iff (rst)
		(power_up && RETAIN && !take) |=> $stable(stages))
		else $error("retentive restart lost stage contents");
	// The reset edge itself clears the previous level, so skip the edge after it
	chk_edge_prev: assert property (@(posedge core_clk) disable iff (rst)
		(!$past(rst) && $past(trigger) && trigger) |-> !rise)
		else $error("edge seen while trigger held high");
	chk_idle_out: assert property (@(posedge core_clk) disable iff (rst)
		(!take && !power_up) |=> $stable(stage_out))
		else $error("output changed without a shift");
	chk_stall_hold: assert property (@(posedge core_clk) disable iff (rst)
		(!drain_ready && !power_up) |=> $stable(stages))
		else $error("stages changed while draining was stalled");
	// req_ready is a registered copy, so it shows a full FIFO one edge late
	chk_ready_lag: assert property (@(posedge core_clk) disable iff (rst)
		!$past(rst) |-> req_ready == $past(fifo_ready))
		else $error("queue ready flag does not lag the FIFO by one cycle");
	// Reset must clear the outputs even though the other checks are off then
	chk_reset_clear: assert property (@(posedge core_clk)
		rst |=> (stages == STAGE_RESET && !stage_out && !req_ready))
		else $error("reset did not clear the outputs");
endmodule

// Valid/ready FIFO for shift requests; depth must be a power of two
// One extra pointer bit tells full from empty without a separate counter
module esr_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Full when the pointers differ by exactly the depth
	assign in_ready = (wptr - rptr) != (AW+1)'(DEPTH);
	assign out_valid = wptr != rptr;
	// Head word is read without a register so it is valid together with out_valid
	assign out_data = mem[rptr[AW-1:0]];

	// Storage is not reset; out_valid alone says whether the head word means anything
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (push) begin
				wptr <= wptr + 1'b1;
			end
			if (pop) begin
				rptr <= rptr + 1'b1;
			end
		end
	end

	chk_fifo_depth: assert property (@(posedge core_clk) disable iff (rst)
		(wptr - rptr) <= (AW+1)'(DEPTH))
		else $error("request FIFO count exceeds its depth");
endmodule
`default_nettype wire

/* test/esr_src_model.sv */
// Purpose: Upstream logic feeding trigger, serial data and direction
// Assumes: go is held for one cycle per wanted trigger edge
// Notes: serial_in toggles while idle so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
module esr_src_model (
	input wire logic core_clk,
	input wire logic go,
	input wire logic d,
	input wire logic dr,
	output logic trigger = 1'h0,
	output logic serial_in = 1'h0,
	output logic dir = 1'h0
);
	// Trigger drops for a cycle between edges, two cycles per request
	always @(posedge core_clk) begin
		trigger <= #1 go & ~trigger;
		serial_in <= #1 go ? d : ~serial_in;
		dir <= #1 go ? dr : dir;
	end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the shift register block
// Assumes: Default OUT_SEL (last stage) and RETAIN off
// Notes: want holds the expected stage contents
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import esr_pkg::*;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic power_up = 1'h0;
	logic drain_ready = 1'h1;
	logic go = 1'h0;
	logic d = 1'h0;
	logic dr = 1'h0;
	wire logic trigger, serial_in, dir, stage_out, req_ready;
	wire logic [STAGES-1:0] stages;
	logic [7:0] want = STAGE_RESET;
	logic [7:0] w;
	int miscompares = 0;
	int cmp_count = 0;
	esr_shift_reg u_esr_shift_reg (.core_clk, .rst, .power_up, .trigger, .serial_in,
		.dir, .drain_ready, .stage_out, .stages, .req_ready);
	// One source feeding the single block instance
	esr_src_model u_esr_src_model (.core_clk, .go, .d, .dr, .trigger, .serial_in, .dir);
	initial forever #4 core_clk = ~core_clk;
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(string nm, logic [8:0] e, logic [8:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic push(logic b, logic r);
		go = 1'h1;
		d = b;
		dr = r;
		tick(1);
		go = 1'h0;
		tick(1);
		want = r ? {b, want[7:1]} : {want[6:0], b};
	endtask
	task automatic t_updown;
		push(1'h1, 1'h0);
		push(1'h1, 1'h0);
		push(1'h0, 1'h0);
		tick(4);
		check("stages", {want[7], want}, {stage_out, stages});
		push(1'h1, 1'h1);
		push(1'h0, 1'h1);
		push(1'h1, 1'h1);
		tick(4);
		check("stages", {want[7], want}, {stage_out, stages});
	endtask
	task automatic t_stall;
		drain_ready = 1'h0;
		for (int i = 0; i < FIFO_DEPTH; i++) push(i[0] ^ i[3], 1'h0);
		w = want;
		push(1'h1, 1'h0);
		push(1'h1, 1'h0);
		check("req_ready", 9'h000, {8'h00, req_ready});
		want = w;
		drain_ready = 1'h1;
		tick(40);
		check("stages", {want[7], want}, {stage_out, stages});
		check("req_ready", 9'h001, {8'h00, req_ready});
	endtask
	task automatic t_restart;
		power_up = 1'h1;
		tick(1);
		power_up = 1'h0;
		want = STAGE_RESET;
		tick(2);
		check("stages", {want[7], want}, {stage_out, stages});
		push(1'h1, 1'h0);
		tick(4);
		check("stages", {want[7], want}, {stage_out, stages});
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		tick(10);
		rst = 1'h0;
		tick(2);
		t_updown();
		t_stall();
		t_restart();
		test_done();
	end
	// Run needs about 150 cycles
	initial begin
		tick(3000);
		miscompares++;
		test_done();
	end
endmodule
`default_nettype wire
